// ---- common/grc_regs.svh ----
// Constants of the gateway record and command link
`ifndef GRC_REGS_SVH
`define GRC_REGS_SVH
// Command query
`define GRC_OP_AUTO_ADDR 8'hE1
`define GRC_ERR_NONE 7'h00
`define GRC_ERR_OPCODE 7'h01
`define GRC_CMD_LEN 6'd3
// Record addressing
`define GRC_IDX_RECORD 8'h01
`define GRC_IDX_SELECT 8'h44
`define GRC_SUBSLOT 8'h01
`define GRC_SLOT_SEG1 8'h00
`define GRC_SLOT_SEG2 8'h64
// Function indices
`define GRC_FN_IMG_RD 8'h01
`define GRC_FN_IMG_WR 8'h02
`define GRC_FN_PAR_EXP 8'h04
`define GRC_FN_PAR_CUR 8'h06
`define GRC_FN_CFG_WR 8'h08
// Reply and request layout
`define GRC_IMG_FIRST 6'd2
`define GRC_IMG_LAST 6'd33
`define GRC_IMG_STS 6'd35
`define GRC_IMG_LEN 6'd36
`define GRC_PAR_BYTE 6'd2
`define GRC_PAR_LEN 6'd4
`define GRC_CFG_HI 6'd4
`define GRC_CFG_LO 6'd5
`define GRC_ST_OK 4'h0
`define GRC_ST_NOK 4'h1
// Host register offsets
`define GRC_REG_CTRL 10'h000
`define GRC_REG_GO 10'h004
`define GRC_REG_STATUS 10'h008
`define GRC_REG_MASK 10'h00C
`define GRC_REG_RXCNT 10'h010
`define GRC_TXBUF_PAGE 2'h1
`define GRC_RXBUF_PAGE 2'h2
`define GRC_BUF_BYTES 6'd36
// Reset values
`define GRC_MAP_RST 8'h01
`define GRC_WMAP_RST 8'h02
`define GRC_CTRL_RST 32'h0101_0000
`endif

// ---- common/grc_pkg.sv ----
// Types shared by both ends of the record link
package grc_pkg;
  typedef enum logic [2:0] {K_CMD, K_RD, K_WR, K_MAP_RD, K_MAP_WR} grc_kind_t;
  typedef enum logic {DS_RECV, DS_SEND} grc_dstate_t;
  typedef enum logic [1:0] {HS_IDLE, HS_SEND, HS_WAIT} grc_hstate_t;
endpackage

// ---- common/grc_if.sv ----
// Link between the controller end and the gateway end
`timescale 1ns/100ps
interface grc_if;
  import grc_pkg::*;
  grc_kind_t h2d_kind;
  logic [7:0] h2d_slot;
  logic [7:0] h2d_index;
  logic [7:0] h2d_subslot;
  logic h2d_valid;
  logic [7:0] h2d_data;
  logic h2d_last;
  logic d2h_valid;
  logic [7:0] d2h_data;
  logic d2h_last;
  logic d2h_nok;
  modport dev (
    input h2d_kind, h2d_slot, h2d_index, h2d_subslot,
    input h2d_valid, h2d_data, h2d_last,
    output d2h_valid, d2h_data, d2h_last, d2h_nok
  );
  modport host (
    output h2d_kind, h2d_slot, h2d_index, h2d_subslot,
    output h2d_valid, h2d_data, h2d_last,
    input d2h_valid, d2h_data, d2h_last, d2h_nok
  );
endinterface

// ---- hdl/grc_device.sv ----
// Gateway end: command query and record request handler
// Overview of operation
// - Query opcode E1, toggle bit7, segment bit0
// - Query reply payload one byte, toggle echoed
// - Auto addressing flag in reply byte 2 bit0
// - Records use index 01, subslot 01, slot 0/100
// - Controller addresses subslot 1 before requests
// - Input image read through read map 01
// - Image reply nibble per node, status byte 35
// - Output image write through write map 02
// - Record write status mirrors segment status
// - Every record answer reports OK or NOK
// - Controller selects node through index 44 first
// - Config write map 08, two bytes per node
// - Map 04 returns expected parameter, byte 2
// - Map 06 returns current parameter, byte 2
`timescale 1ns/100ps
`include "grc_regs.svh"
module grc_device (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Link to the controller
  grc_if.dev lnk,
  // Gateway side
  input wire logic [1:0] auto_addr_en,
  input wire logic [1:0] seg_ok,
  input wire logic [1:0][63:0][3:0] input_image,
  input wire logic [1:0][63:0][3:0] exp_param,
  input wire logic [1:0][63:0][3:0] cur_param,
  output logic [1:0][63:0][3:0] output_image,
  output logic [1:0][63:0][15:0] exp_cfg
);
  import grc_pkg::*;

  grc_dstate_t st_q;
  grc_kind_t rkind_q;
  logic [5:0] bcnt_q;
  logic [5:0] rcnt_q;
  logic [5:0] rlen_q;
  logic [7:0] rmap_q;
  logic [7:0] wmap_q;
  logic [7:0] rfunc_q;
  logic [5:0] sel_q;
  logic sel_ok_q;
  logic rseg_q;
  logic rnok_q;
  logic [7:0] op_q;
  logic tgl_q;
  logic cseg_q;
  logic d_valid_q;
  logic [7:0] d_data_q;
  logic d_last_q;
  logic d_nok_q;
  logic beat;
  logic seg;
  logic slot_ok;
  logic rec_ok;
  logic sel_wr;
  logic ok_now;
  logic [7:0] func;
  logic [4:0] j;
  logic [4:0] jr;
  logic [7:0] rbyte;
  logic [5:0] rlen_d;
  logic [6:0] err;

  assign beat = st_q == DS_RECV && lnk.h2d_valid;
  assign seg = lnk.h2d_slot == `GRC_SLOT_SEG2;
  assign slot_ok = lnk.h2d_slot == `GRC_SLOT_SEG1 || seg;
  assign rec_ok = slot_ok && lnk.h2d_index == `GRC_IDX_RECORD
    && lnk.h2d_subslot == `GRC_SUBSLOT;
  assign sel_wr = lnk.h2d_kind == K_WR && slot_ok
    && lnk.h2d_index == `GRC_IDX_SELECT && lnk.h2d_subslot == `GRC_SUBSLOT;
  assign func = lnk.h2d_kind == K_RD ? rmap_q : wmap_q;
  assign j = 5'(bcnt_q - `GRC_IMG_FIRST);
  assign jr = 5'(rcnt_q - `GRC_IMG_FIRST);
  assign err = op_q == `GRC_OP_AUTO_ADDR ? `GRC_ERR_NONE : `GRC_ERR_OPCODE;

  // Request acceptance
  always_comb begin
    ok_now = 1'b0;
    unique case (lnk.h2d_kind)
      K_CMD: ok_now = 1'b1;
      K_RD: ok_now = rec_ok && (func == `GRC_FN_IMG_RD
        || (func == `GRC_FN_PAR_EXP || func == `GRC_FN_PAR_CUR)
        && sel_ok_q);
      K_WR: ok_now = sel_wr || rec_ok && seg_ok[seg]
        && (func == `GRC_FN_IMG_WR
        || func == `GRC_FN_CFG_WR && sel_ok_q);
      K_MAP_RD: ok_now = lnk.h2d_index == `GRC_FN_IMG_RD
        || lnk.h2d_index == `GRC_FN_PAR_EXP
        || lnk.h2d_index == `GRC_FN_PAR_CUR;
      K_MAP_WR: ok_now = lnk.h2d_index == `GRC_FN_IMG_WR
        || lnk.h2d_index == `GRC_FN_CFG_WR;
      default: ok_now = 1'b0;
    endcase
  end

  // Reply length
  always_comb begin
    rlen_d = 6'd1;
    if (lnk.h2d_kind == K_CMD) begin
      rlen_d = `GRC_CMD_LEN;
    end else if (lnk.h2d_kind == K_RD && ok_now) begin
      rlen_d = func == `GRC_FN_IMG_RD ? `GRC_IMG_LEN : `GRC_PAR_LEN;
    end
  end

  // Reply byte
  always_comb begin
    rbyte = 8'h00;
    unique case (rkind_q)
      K_CMD: begin
        if (rcnt_q == 6'd0) begin
          rbyte = op_q;
        end else if (rcnt_q == 6'd1) begin
          rbyte = {tgl_q, err};
        end else begin
          rbyte = {7'h00, err == `GRC_ERR_NONE
            && auto_addr_en[cseg_q]};
        end
      end
      K_RD: begin
        if (rnok_q) begin
          rbyte = {4'h0, `GRC_ST_NOK};
        end else if (rfunc_q == `GRC_FN_IMG_RD) begin
          if (rcnt_q >= `GRC_IMG_FIRST && rcnt_q <= `GRC_IMG_LAST) begin
            rbyte[7:4] = jr[3:0] == 4'h0 ? 4'h0
              : input_image[rseg_q][{jr[4], jr[3:0], 1'b0}];
            rbyte[3:0] = input_image[rseg_q][{jr[4], jr[3:0], 1'b1}];
          end else if (rcnt_q == `GRC_IMG_STS) begin
            rbyte = {4'h0, `GRC_ST_OK};
          end
        end else if (rcnt_q == `GRC_PAR_BYTE) begin
          rbyte[3:0] = rfunc_q == `GRC_FN_PAR_EXP
            ? exp_param[rseg_q][sel_q]
            : cur_param[rseg_q][sel_q];
        end
      end
      default: rbyte = {4'h0, rnok_q ? `GRC_ST_NOK : `GRC_ST_OK};
    endcase
  end

  // Receive and send sequencing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= DS_RECV;
      bcnt_q <= 6'd0;
      rcnt_q <= 6'd0;
      rlen_q <= 6'd1;
      rkind_q <= K_CMD;
      rfunc_q <= 8'h00;
      rseg_q <= 1'b0;
      rnok_q <= 1'b0;
    end else if (st_q == DS_RECV) begin
      if (beat) begin
        bcnt_q <= lnk.h2d_last ? 6'd0
          : (bcnt_q == 6'h3F ? bcnt_q : bcnt_q + 6'd1);
        if (lnk.h2d_last) begin
          st_q <= DS_SEND;
          rcnt_q <= 6'd0;
          rlen_q <= rlen_d;
          rkind_q <= lnk.h2d_kind;
          rfunc_q <= func;
          rseg_q <= seg;
          rnok_q <= !ok_now;
        end
      end
    end else begin
      rcnt_q <= rcnt_q + 6'd1;
      if (rcnt_q == rlen_q - 6'd1) begin
        st_q <= DS_RECV;
      end
    end
  end

  // Reply drive
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      d_valid_q <= 1'b0;
      d_data_q <= 8'h00;
      d_last_q <= 1'b0;
      d_nok_q <= 1'b0;
    end else begin
      d_valid_q <= st_q == DS_SEND;
      d_data_q <= st_q == DS_SEND ? rbyte : 8'h00;
      d_last_q <= st_q == DS_SEND && rcnt_q == rlen_q - 6'd1;
      d_nok_q <= st_q == DS_SEND && rnok_q;
    end
  end

  // Command query fields
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      op_q <= 8'h00;
      tgl_q <= 1'b0;
      cseg_q <= 1'b0;
    end else if (beat && lnk.h2d_kind == K_CMD) begin
      if (bcnt_q == 6'd0) begin
        op_q <= lnk.h2d_data;
      end else if (bcnt_q == 6'd1) begin
        tgl_q <= lnk.h2d_data[7];
        cseg_q <= lnk.h2d_data[0];
      end
    end
  end

  // Function maps and node selector
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rmap_q <= `GRC_MAP_RST;
      wmap_q <= `GRC_WMAP_RST;
      sel_q <= 6'd0;
      sel_ok_q <= 1'b0;
    end else if (beat && ok_now) begin
      if (lnk.h2d_last && lnk.h2d_kind == K_MAP_RD) begin
        rmap_q <= lnk.h2d_index;
      end
      if (lnk.h2d_last && lnk.h2d_kind == K_MAP_WR) begin
        wmap_q <= lnk.h2d_index;
      end
      if (sel_wr && bcnt_q == `GRC_IMG_FIRST) begin
        sel_q <= lnk.h2d_data[5:0];
        sel_ok_q <= lnk.h2d_data[4:0] != 5'h00;
      end
    end
  end

  // Output image and expected configuration stores
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      output_image <= '0;
      exp_cfg <= '0;
    end else if (beat && ok_now && rec_ok && lnk.h2d_kind == K_WR) begin
      if (func == `GRC_FN_IMG_WR && bcnt_q >= `GRC_IMG_FIRST
          && bcnt_q <= `GRC_IMG_LAST) begin
        if (j[3:0] != 4'h0) begin
          output_image[seg][{j[4], j[3:0], 1'b0}] <=
            lnk.h2d_data[7:4];
        end
        output_image[seg][{j[4], j[3:0], 1'b1}] <= lnk.h2d_data[3:0];
      end
      if (func == `GRC_FN_CFG_WR && bcnt_q == `GRC_CFG_HI) begin
        exp_cfg[seg][sel_q][15:8] <= lnk.h2d_data;
      end
      if (func == `GRC_FN_CFG_WR && bcnt_q == `GRC_CFG_LO) begin
        exp_cfg[seg][sel_q][7:0] <= lnk.h2d_data;
      end
    end
  end

  assign lnk.d2h_valid = d_valid_q;
  assign lnk.d2h_data = d_data_q;
  assign lnk.d2h_last = d_last_q;
  assign lnk.d2h_nok = d_nok_q;
endmodule

// ---- hdl/grc_host.sv ----
// Controller end: issues requests from a register port
`timescale 1ns/100ps
`include "grc_regs.svh"
module grc_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [9:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // Link to the gateway
  grc_if.host lnk
);
  import grc_pkg::*;

  grc_hstate_t st_q;
  logic [31:0] ctrl_q;
  logic [5:0] len_q;
  logic [5:0] tcnt_q;
  logic [5:0] rxcnt_q;
  logic [7:0] txbuf_q [36];
  logic [7:0] rxbuf_q [36];
  logic [1:0] sts_q;
  logic [1:0] mask_q;
  logic [1:0] ev;
  logic [31:0] rdata_q;
  logic irq_q;
  logic h_valid_q;
  logic [7:0] h_data_q;
  logic h_last_q;
  logic idle;
  logic [5:0] bidx;
  logic done;

  assign idle = st_q == HS_IDLE;
  assign bidx = reg_addr[7:2];
  assign done = st_q == HS_WAIT && lnk.d2h_valid && lnk.d2h_last;
  assign ev = {done && lnk.d2h_nok, done};

  // Request header and start
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_q <= `GRC_CTRL_RST;
      len_q <= 6'd1;
    end else if (reg_wr && idle) begin
      if (reg_addr == `GRC_REG_CTRL) begin
        ctrl_q <= reg_wdata;
      end
      if (reg_addr == `GRC_REG_GO) begin
        len_q <= reg_wdata[5:0] == 6'd0 ? 6'd1 : reg_wdata[5:0];
      end
    end
  end

  // Transfer sequencing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= HS_IDLE;
      tcnt_q <= 6'd0;
      rxcnt_q <= 6'd0;
      h_valid_q <= 1'b0;
      h_data_q <= 8'h00;
      h_last_q <= 1'b0;
    end else begin
      h_valid_q <= 1'b0;
      h_last_q <= 1'b0;
      unique case (st_q)
        HS_IDLE: begin
          if (reg_wr && reg_addr == `GRC_REG_GO) begin
            st_q <= HS_SEND;
            tcnt_q <= 6'd0;
            rxcnt_q <= 6'd0;
          end
        end
        HS_SEND: begin
          h_valid_q <= 1'b1;
          h_data_q <= tcnt_q < `GRC_BUF_BYTES ? txbuf_q[tcnt_q] : 8'h00;
          h_last_q <= tcnt_q == len_q - 6'd1;
          tcnt_q <= tcnt_q + 6'd1;
          if (tcnt_q == len_q - 6'd1) begin
            st_q <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (lnk.d2h_valid) begin
            rxcnt_q <= rxcnt_q == 6'h3F ? rxcnt_q : rxcnt_q + 6'd1;
            if (lnk.d2h_last) begin
              st_q <= HS_IDLE;
            end
          end
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  // Transmit and receive buffers
  always_ff @(posedge ref_clk) begin
    if (reg_wr && idle && reg_addr[9:8] == `GRC_TXBUF_PAGE
        && bidx < `GRC_BUF_BYTES) begin
      txbuf_q[bidx] <= reg_wdata[7:0];
    end
    if (st_q == HS_WAIT && lnk.d2h_valid && rxcnt_q < `GRC_BUF_BYTES) begin
      rxbuf_q[rxcnt_q] <= lnk.d2h_data;
    end
  end

  // Sticky events, mask and interrupt
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sts_q <= 2'h0;
      mask_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `GRC_REG_STATUS) begin
        sts_q <= (sts_q & ~reg_wdata[1:0]) | ev;
      end else begin
        sts_q <= sts_q | ev;
      end
      if (reg_wr && reg_addr == `GRC_REG_MASK) begin
        mask_q <= reg_wdata[1:0];
      end
      irq_q <= |(sts_q & mask_q);
    end
  end

  // Register read
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_q <= 32'h0000_0000;
      if (reg_addr == `GRC_REG_CTRL) begin
        rdata_q <= ctrl_q;
      end else if (reg_addr == `GRC_REG_STATUS) begin
        rdata_q <= {30'h0, sts_q};
      end else if (reg_addr == `GRC_REG_MASK) begin
        rdata_q <= {30'h0, mask_q};
      end else if (reg_addr == `GRC_REG_RXCNT) begin
        rdata_q <= {23'h0, !idle, 2'h0, rxcnt_q};
      end else if (reg_addr[9:8] == `GRC_TXBUF_PAGE
          && bidx < `GRC_BUF_BYTES) begin
        rdata_q <= {24'h0, txbuf_q[bidx]};
      end else if (reg_addr[9:8] == `GRC_RXBUF_PAGE
          && bidx < `GRC_BUF_BYTES) begin
        rdata_q <= {24'h0, rxbuf_q[bidx]};
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign lnk.h2d_kind = grc_kind_t'(ctrl_q[2:0]);
  assign lnk.h2d_index = ctrl_q[15:8];
  assign lnk.h2d_slot = ctrl_q[23:16];
  assign lnk.h2d_subslot = ctrl_q[31:24];
  assign lnk.h2d_valid = h_valid_q;
  assign lnk.h2d_data = h_data_q;
  assign lnk.h2d_last = h_last_q;
endmodule

// ---- dv/grc_checker.sv ----
// Checker of the record link between both ends
`timescale 1ns/100ps
module grc_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Request side
  input wire grc_pkg::grc_kind_t h2d_kind,
  input wire logic [7:0] h2d_slot,
  input wire logic h2d_valid,
  input wire logic [7:0] h2d_data,
  input wire logic h2d_last,
  // Reply side
  input wire logic d2h_valid,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_last,
  input wire logic d2h_nok
);
  import grc_pkg::*;
  logic [5:0] rcnt_q;
  logic [5:0] hcnt_q;
  logic [7:0] tg_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Reply beat position
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rcnt_q <= 6'h00;
    end else if (d2h_valid) begin
      rcnt_q <= d2h_last ? 6'h00 : rcnt_q + 6'h01;
    end
  end
  // Request beat position and toggle byte
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hcnt_q <= 6'h00;
      tg_q <= 8'h00;
    end else if (h2d_valid) begin
      hcnt_q <= h2d_last ? 6'h00 : hcnt_q + 6'h01;
      if (hcnt_q == 6'h01) begin
        tg_q <= h2d_data;
      end
    end
  end
  AST_REPLY_TURN: assert property (h2d_valid && h2d_last
    |-> ##2 d2h_valid)
    else $error("reply did not follow request");
  AST_REPLY_RUN: assert property (d2h_valid && !d2h_last |=> d2h_valid)
    else $error("reply beats not back to back");
  AST_QUIET_HOST: assert property (d2h_valid |-> !h2d_valid)
    else $error("request beat during reply");
  AST_QUERY_LEN: assert property (h2d_valid && h2d_last && h2d_kind == K_CMD
    |-> ##2 (d2h_valid && !d2h_last) [*2] ##1 (d2h_valid && d2h_last))
    else $error("query reply not three bytes");
  AST_QUERY_TOGGLE: assert property (d2h_valid && h2d_kind == K_CMD
    && rcnt_q == 6'h01 |-> d2h_data[7] == tg_q[7])
    else $error("query toggle not echoed");
  AST_QUERY_FLAG: assert property (d2h_valid && h2d_kind == K_CMD
    && rcnt_q == 6'h02 |-> d2h_data[7:1] == 7'h00)
    else $error("query flag byte has stray bits");
  AST_READ_HEAD: assert property (d2h_valid && h2d_kind == K_RD && !d2h_nok
    && rcnt_q < 6'h02 |-> d2h_data == 8'h00)
    else $error("read reply head not zero");
  AST_IMG_TAIL: assert property (d2h_valid && h2d_kind == K_RD
    && rcnt_q == 6'd35 |-> d2h_last && d2h_data == 8'h00)
    else $error("image status byte wrong");
  AST_NOK_BYTE: assert property (d2h_valid && d2h_nok
    |-> d2h_last && d2h_data == 8'h01)
    else $error("refusal reply wrong");
  AST_WR_STATUS: assert property (d2h_valid
    && h2d_kind inside {K_WR, K_MAP_RD, K_MAP_WR}
    |-> d2h_last && d2h_data == {7'h00, d2h_nok})
    else $error("write status reply wrong");
  AST_SLOT_NOK: assert property (d2h_valid && h2d_kind inside {K_RD, K_WR}
    && !(h2d_slot inside {8'h00, 8'h64}) |-> d2h_nok)
    else $error("bad slot not refused");
endmodule

// ---- dv/tb_top.sv ----
// Bench joining controller end and gateway end
`timescale 1ns/100ps
module tb_top;
  import grc_pkg::*;
  logic ref_clk;
  logic sys_rst;
  logic [9:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic irq;
  logic [1:0] auto_addr_en;
  logic [1:0] seg_ok;
  logic [1:0][63:0][3:0] input_image;
  logic [1:0][63:0][3:0] exp_param;
  logic [1:0][63:0][3:0] cur_param;
  logic [1:0][63:0][3:0] output_image;
  logic [1:0][63:0][15:0] exp_cfg;
  logic [7:0] rx [36];
  logic [7:0] b;
  logic [31:0] v;
  int n_fail;
  int n_checks;
  grc_if lnk ();
  grc_host grc_host_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .lnk(lnk));
  grc_device grc_device_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .lnk(lnk), .auto_addr_en(auto_addr_en), .seg_ok(seg_ok),
    .input_image(input_image), .exp_param(exp_param),
    .cur_param(cur_param), .output_image(output_image), .exp_cfg(exp_cfg));
  grc_checker grc_checker_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .h2d_kind(lnk.h2d_kind), .h2d_slot(lnk.h2d_slot),
    .h2d_valid(lnk.h2d_valid), .h2d_data(lnk.h2d_data),
    .h2d_last(lnk.h2d_last), .d2h_valid(lnk.d2h_valid),
    .d2h_data(lnk.d2h_data), .d2h_last(lnk.d2h_last), .d2h_nok(lnk.d2h_nok));
  function automatic logic [3:0] nib(int s, int n);
    return 4'(n * 3 + s + 1);
  endfunction
  // Packed image byte k, node 0 and node 32 slots left zero
  function automatic logic [7:0] ibyte(int s, int k);
    int n;
    n = (k / 16) * 32 + (k % 16) * 2;
    return {(k % 16 == 0) ? 4'h0 : nib(s, n), nib(s, n + 1)};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [9:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(logic [9:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
  endtask
  // Send one frame, wait for done, fetch the reply
  task automatic frame(grc_kind_t k, logic [7:0] ix, logic [7:0] sl,
                       int n, int len);
    int i;
    wr(10'h008, 32'h3);
    wr(10'h000, {8'h01, sl, ix, 5'h00, k});
    wr(10'h004, 32'(n));
    v = 32'h0;
    for (i = 0; i < 200 && v[0] !== 1'b1; i++) begin
      rd(10'h008);
    end
    if (v[0] !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
    rd(10'h010);
    chk("reply length", 32'(len), v & 32'h3F);
    for (i = 0; i < len; i++) begin
      rd(10'h200 + 10'(4 * i));
      rx[i] = v[7:0];
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    int s;
    int k;
    n_fail = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    reg_addr = 10'h000;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    auto_addr_en = 2'b10;
    seg_ok = 2'b01;
    for (s = 0; s < 128; s++) begin
      input_image[s / 64][s % 64] = nib(s / 64, s % 64);
      exp_param[s / 64][s % 64] = nib(s / 64, s % 64) ^ 4'h5;
      cur_param[s / 64][s % 64] = nib(s / 64, s % 64) ^ 4'hA;
    end
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd(10'h000);
    chk("ctrl reset", 32'h0101_0000, v);
    rd(10'h3F0);
    chk("unmapped read", 32'h0, v);
    for (s = 0; s < 2; s++) begin
      wr(10'h100, 32'hE1);
      wr(10'h104, s[0] ? 32'h01 : 32'h80);
      frame(K_CMD, 8'h01, 8'h00, 2, 3);
      chk("query op", 32'hE1, 32'(rx[0]));
      chk("query toggle", s[0] ? 32'h0 : 32'h80, 32'(rx[1]));
      chk("query flag", 32'(auto_addr_en[s]), 32'(rx[2]));
    end
    // Wrong opcode on segment 2: error code set, flag held low
    wr(10'h100, 32'h60);
    frame(K_CMD, 8'h01, 8'h00, 2, 3);
    chk("bad op echo", 32'h60, 32'(rx[0]));
    chk("bad op err", 32'h01, 32'(rx[1]));
    chk("bad op flag", 32'h0, 32'(rx[2]));
    for (s = 0; s < 2; s++) begin
      frame(K_RD, 8'h01, s[0] ? 8'h64 : 8'h00, 1, 36);
      for (k = 0; k < 36; k++) begin
        b = (k < 2 || k > 33) ? 8'h00 : ibyte(s, k - 2);
        chk("image byte", 32'(b), 32'(rx[k]));
      end
    end
    chk("irq masked", 32'h0, 32'(irq));
    wr(10'h00C, 32'h2);
    frame(K_RD, 8'h01, 8'h05, 1, 1);
    chk("bad slot", 32'h1, 32'(rx[0]));
    rd(10'h008);
    chk("status", 32'h3, v);
    chk("irq on", 32'h1, 32'(irq));
    wr(10'h008, 32'h3);
    @(posedge ref_clk);
    #1 chk("irq off", 32'h0, 32'(irq));
    wr(10'h100, 32'h0);
    wr(10'h104, 32'h0);
    for (k = 0; k < 32; k++) begin
      wr(10'h108 + 10'(4 * k), 32'(8'(k * 7 + 3)));
    end
    frame(K_WR, 8'h01, 8'h00, 36, 1);
    chk("write ok", 32'h0, 32'(rx[0]));
    for (k = 0; k < 32; k++) begin
      b = 8'(k * 7 + 3);
      s = (k / 16) * 32 + (k % 16) * 2;
      chk("out lo", 32'(b[3:0]), 32'(output_image[0][s + 1]));
      if (k % 16 != 0) begin
        chk("out hi", 32'(b[7:4]), 32'(output_image[0][s]));
      end
    end
    frame(K_WR, 8'h01, 8'h64, 36, 1);
    chk("seg down", 32'h1, 32'(rx[0]));
    chk("out kept", 32'h0, 32'(output_image[1][8:1]));
    frame(K_MAP_RD, 8'h04, 8'h00, 1, 1);
    chk("map ok", 32'h0, 32'(rx[0]));
    frame(K_RD, 8'h01, 8'h00, 1, 1);
    chk("no node", 32'h1, 32'(rx[0]));
    wr(10'h108, 32'h25);
    frame(K_WR, 8'h44, 8'h00, 3, 1);
    chk("select ok", 32'h0, 32'(rx[0]));
    frame(K_MAP_RD, 8'h03, 8'h00, 1, 1);
    chk("bad map", 32'h1, 32'(rx[0]));
    frame(K_RD, 8'h01, 8'h00, 1, 4);
    chk("exp param", 32'(exp_param[0][37]), 32'(rx[2]));
    frame(K_MAP_RD, 8'h06, 8'h00, 1, 1);
    frame(K_RD, 8'h01, 8'h64, 1, 4);
    chk("cur param", 32'(cur_param[1][37]), 32'(rx[2]));
    frame(K_MAP_WR, 8'h08, 8'h00, 1, 1);
    wr(10'h110, 32'hA5);
    wr(10'h114, 32'h3C);
    frame(K_WR, 8'h01, 8'h00, 6, 1);
    chk("config ok", 32'h0, 32'(rx[0]));
    chk("config", 32'hA53C, 32'(exp_cfg[0][37]));
    print_verdict();
  end
endmodule
